// ---- hw/qdac_pkg.sv ----
// Constants shared by the four-channel converter load logic
package qdac_pkg;
   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int WORD_W = 12;
   localparam int VAL_W  = 10;
   localparam int SEL_W  = 2;
   localparam int NUM_CH = 4;

   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] OFS_LOAD = 8'h00;
   localparam logic [7:0] OFS_FIRST_CH = 8'h04;
   localparam logic [7:0] OFS_CH1  = 8'h08;
   localparam logic [7:0] OFS_CH2  = 8'h0C;
   localparam logic [7:0] OFS_CH3  = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;

   // Load word fields: word bit 0 (most significant) sits at data bit 11
   localparam int SEL_MSB = 11;
   localparam int SEL_LSB = 10;
   localparam int VAL_MSB = 9;

   // Status register bit positions
   localparam int STAT_PWR_LOW = 0;
   localparam int STAT_START   = 1;
   localparam int STAT_BACKUP  = 2;
   localparam int STAT_NORMAL  = 3;

   // Reset values and straight binary code points
   localparam logic [9:0]  VAL_RST   = 10'h000;
   localparam logic [11:0] WORD_RST  = 12'h000;
   localparam logic [9:0]  CODE_ZERO = 10'h000;
   localparam logic [9:0]  CODE_HALF = 10'h200;
   localparam logic [9:0]  CODE_FULL = 10'h3FF;

   // Settling interval the controller must leave between conversions
   localparam int CLK_PERIOD_NS = 20;
   localparam int SETTLE_NS     = 50000;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- hw/qdac_load_if.sv ----
// Load and clear signals from the decode logic to the channel buffers
`timescale 1ns/10ps
interface qdac_load_if;
   logic [qdac_pkg::NUM_CH-1:0] load_en;
   logic [qdac_pkg::VAL_W-1:0]  value;
   logic                        clear;

   modport ctrl
   (
      output load_en,
      output value,
      output clear
   );
   modport chan
   (
      input  load_en,
      input  value,
      input  clear
   );
endinterface

// ---- hw/qdac_chan_buf.sv ----
// One channel input buffer register
`timescale 1ns/10ps
module qdac_chan_buf
#(
   parameter int CH_IDX = 0
)
(
   // Clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       rst_i,
   // Load and clear from the decode logic
   qdac_load_if.chan                       lif,
   // Held conversion value
   output logic [qdac_pkg::VAL_W-1:0]      value_o
);

   logic [qdac_pkg::VAL_W-1:0] next_value;

   // Clear takes priority: a start pulse with the normal power strap fitted and no backup strap must leave every channel at zero
   always_comb
   begin
      next_value = value_o;
      if (lif.clear)
      begin
         next_value = qdac_pkg::VAL_RST; // RQ11
      end
      else if (lif.load_en[CH_IDX])
      begin
         next_value = lif.value; // RQ1
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         value_o <= qdac_pkg::VAL_RST;
      end
      else
      begin
         value_o <= next_value;
      end
   end
endmodule

// ---- hw/qdac_load_logic.sv ----
// Load logic of the four-channel 10-bit converter output module
// Overview of operation
// [RQ1] Four channels, each with a 10-bit buffer keeping the last value written.
// [RQ2] Word bits 02 to 11 (bit 0 most significant) are the conversion value.
// [RQ3] Word bits 0 and 1 select the channel: 00 to 11 pick channels 0 to 3.
// [RQ4] One write captures select and value together; only that channel changes.
// [RQ5] The controller gives a channel select with every word; none is remembered.
// [RQ6] Values are straight binary: 0000 zero, 1000 half, 1777 full less one step.
// [RQ7] Low or lost computer power forces the load strobe inactive.
// [RQ8] With the backup strap fitted, start does not clear the buffers.
// [RQ9] No status bit; the controller waits the settling time, up to 50 us.
// [RQ10] Only a load instruction addressed to this module changes a buffer.
// [RQ11] With the normal power strap fitted, start clears all buffers to zero.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module qdac_load_logic
(
   // Clock and reset
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_i,
   // Register port
   input  wire logic [qdac_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [qdac_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic      [qdac_pkg::DATA_W-1:0] rdata_o,
   // Supply monitor, start and straps (asynchronous pins)
   input  wire logic                        power_low_i,
   input  wire logic                        start_i,
   input  wire logic                        backup_supply_strap_i,
   input  wire logic                        normal_power_strap_i,
   // Buffered conversion values
   output logic      [qdac_pkg::VAL_W-1:0]  first_output_channel_o,
   output logic      [qdac_pkg::VAL_W-1:0]  dac_ch1_o,
   output logic      [qdac_pkg::VAL_W-1:0]  dac_ch2_o,
   output logic      [qdac_pkg::VAL_W-1:0]  dac_ch3_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic       pwr_low_s;
   logic       start_s;
   logic       backup_s;
   logic       normal_s;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_meta <= 4'h0;
         pin_sync <= 4'h0;
      end
      else
      begin
         pin_meta <= {normal_power_strap_i, backup_supply_strap_i, start_i, power_low_i};
         pin_sync <= pin_meta;
      end
   end

   assign pwr_low_s = pin_sync[0];
   assign start_s   = pin_sync[1];
   assign backup_s  = pin_sync[2];
   assign normal_s  = pin_sync[3];

   ////////////////////////////////////////////////////////////////////////////
   // Load decode
   qdac_load_if lif ();

   logic [qdac_pkg::SEL_W-1:0] wsel;
   logic [qdac_pkg::VAL_W-1:0] wval;
   logic                       load_hit;
   logic                       load_fire;
   logic                       clear_req;
   logic [qdac_pkg::VAL_W-1:0] ch_val [qdac_pkg::NUM_CH];

   assign wsel      = wdata_i[qdac_pkg::SEL_MSB:qdac_pkg::SEL_LSB]; // RQ3
   assign wval      = wdata_i[qdac_pkg::VAL_MSB:0]; // RQ2
   assign load_hit  = wr_i && (addr_i == qdac_pkg::OFS_LOAD); // RQ10
   assign load_fire = load_hit && !pwr_low_s; // RQ7
   // Backup strap wins if both are fitted, so analog output survives restoration
   assign clear_req = start_s && normal_s && !backup_s; // RQ8

   always_comb
   begin
      lif.clear   = clear_req; // RQ11
      lif.value   = wval; // RQ6
      lif.load_en = load_fire ? (4'h1 << wsel) : 4'h0; // RQ4
   end

   genvar gi;
   generate
      for (gi = 0; gi < qdac_pkg::NUM_CH; gi++)
      begin : g_ch
         qdac_chan_buf #(.CH_IDX(gi)) u_buf
         (
            .core_clk_i (core_clk_i),
            .rst_i      (rst_i),
            .lif        (lif),
            .value_o    (ch_val[gi])
         );
      end
   endgenerate

   assign first_output_channel_o = ch_val[0];
   assign dac_ch1_o              = ch_val[1];
   assign dac_ch2_o              = ch_val[2];
   assign dac_ch3_o              = ch_val[3];

   ////////////////////////////////////////////////////////////////////////////
   // Last accepted word and read data
   logic [qdac_pkg::WORD_W-1:0] last_word;
   logic [qdac_pkg::WORD_W-1:0] next_last_word;
   logic [qdac_pkg::DATA_W-1:0] next_rdata;

   always_comb
   begin
      next_last_word = last_word;
      if (load_fire)
      begin
         next_last_word = wdata_i[qdac_pkg::WORD_W-1:0];
      end
      next_rdata = 32'h0000_0000;
      if (rd_i)
      begin
         if (addr_i == qdac_pkg::OFS_LOAD)
         begin
            next_rdata = {20'h00000, last_word};
         end
         else if (addr_i == qdac_pkg::OFS_FIRST_CH)
         begin
            next_rdata = {22'h0, ch_val[0]};
         end
         else if (addr_i == qdac_pkg::OFS_CH1)
         begin
            next_rdata = {22'h0, ch_val[1]};
         end
         else if (addr_i == qdac_pkg::OFS_CH2)
         begin
            next_rdata = {22'h0, ch_val[2]};
         end
         else if (addr_i == qdac_pkg::OFS_CH3)
         begin
            next_rdata = {22'h0, ch_val[3]};
         end
         else if (addr_i == qdac_pkg::OFS_STAT)
         begin
            next_rdata[qdac_pkg::STAT_PWR_LOW] = pwr_low_s;
            next_rdata[qdac_pkg::STAT_START]   = start_s;
            next_rdata[qdac_pkg::STAT_BACKUP]  = backup_s;
            next_rdata[qdac_pkg::STAT_NORMAL]  = normal_s;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         last_word <= qdac_pkg::WORD_RST;
         rdata_o   <= 32'h0000_0000;
      end
      else
      begin
         last_word <= next_last_word;
         rdata_o   <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_load_sel_value: assert property ( // RQ2
      (load_fire && !clear_req) |=> (ch_val[$past(wsel)] == $past(wval)))
      else $error("selected channel did not take the written value");

   a_sel_three_chan: assert property ( // RQ3
      (load_fire && !clear_req && wsel == 2'h3) |=> (dac_ch3_o == $past(wval)))
      else $error("select 11 did not load channel 3");

   a_unsel_chan_hold: assert property ( // RQ4
      (load_fire && !clear_req && wsel != 2'h0) |=> $stable(first_output_channel_o))
      else $error("unselected channel 0 changed on a load");

   a_idle_buf_hold: assert property ( // RQ1
      (!load_fire && !clear_req) |=> ($stable(dac_ch1_o) && $stable(dac_ch2_o)))
      else $error("buffer changed without a load or clear");

   a_half_code_msb: assert property ( // RQ6
      (load_fire && !clear_req && wval == qdac_pkg::CODE_HALF)
      |=> (ch_val[$past(wsel)] == 10'h200))
      else $error("half scale code not stored as straight binary");

   a_pwr_low_gate: assert property ( // RQ7
      (pwr_low_s && !clear_req) [*2]
      |-> ($stable(first_output_channel_o) && $stable(dac_ch3_o)))
      else $error("buffer changed while power is low");

   a_backup_no_clear: assert property ( // RQ8
      (start_s && backup_s && !load_fire) |=> $stable(dac_ch2_o))
      else $error("start cleared a buffer with the backup strap fitted");

   a_foreign_addr: assert property ( // RQ10
      (wr_i && addr_i != qdac_pkg::OFS_LOAD && !clear_req) |=> $stable(dac_ch1_o))
      else $error("write to another address changed a buffer");

   a_start_clear_all: assert property ( // RQ11
      (start_s && normal_s && !backup_s)
      |=> (first_output_channel_o == 10'h000 && dac_ch1_o == 10'h000
           && dac_ch2_o == 10'h000 && dac_ch3_o == 10'h000))
      else $error("start did not clear all buffers");

   a_read_chan_two: assert property ( // RQ1
      (rd_i && addr_i == qdac_pkg::OFS_CH2) |=> (rdata_o == {22'h0, $past(dac_ch2_o)}))
      else $error("channel 2 read data wrong");

   c_load_chan3:   cover property (load_fire && wsel == 2'h3);
   c_pwr_blocked:  cover property (load_hit && pwr_low_s);
   c_start_clear:  cover property (clear_req ##1 load_fire);
   c_backup_start: cover property (start_s && backup_s);
endmodule

// ---- verification/qdac_ctrl_model.sv ----
// Subsystem controller model driving the register port of the load logic
`timescale 1ns/10ps
module qdac_ctrl_model
(
   // Clock
   input  wire logic                        core_clk_i,
   // Register port, master side
   output logic      [qdac_pkg::ADDR_W-1:0] addr_o,
   output logic      [qdac_pkg::DATA_W-1:0] wdata_o,
   output logic                             wr_o,
   output logic                             rd_o,
   input  wire logic [qdac_pkg::DATA_W-1:0] rdata_i
);
   initial
   begin
      addr_o  = 8'h00;
      wdata_o = 32'h00000000;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Every word carries its own select; nothing is relied on between writes
   task automatic wr_word(input logic [7:0] a, input logic [1:0] s, input logic [9:0] v);
      @(posedge core_clk_i);
      addr_o  <= a;
      wdata_o <= {20'h00000, s, v};
      wr_o    <= 1'b1;
      @(posedge core_clk_i);
      wr_o    <= 1'b0;
      // Idle data lines must not keep the last word
      wdata_o <= ~{20'h00000, s, v};
      // No completion flag, so the settling time is simply waited out
      repeat (qdac_pkg::SETTLE_CYC) @(posedge core_clk_i);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge core_clk_i);
      rd_o   <= 1'b0;
      @(posedge core_clk_i);
      d = rdata_i;
   endtask
endmodule

// ---- verification/tb_quad_dac_load_logic.sv ----
// Self-checking bench for the four-channel converter load logic
`timescale 1ns/10ps
module tb_quad_dac_load_logic;
   logic                        core_clk_i;
   logic                        rst_i;
   logic [qdac_pkg::ADDR_W-1:0] addr;
   logic [qdac_pkg::DATA_W-1:0] wdata;
   logic                        wr;
   logic                        rd;
   logic [qdac_pkg::DATA_W-1:0] rdata;
   logic                        pwr_low;
   logic                        start;
   logic                        backup;
   logic                        normal;
   logic [qdac_pkg::VAL_W-1:0]  outv [4];
   int                          mdl [4];
   int                          words [$];
   int                          fails;
   int                          checked;
   logic [31:0]                 rv;
   qdac_load_logic dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .power_low_i(pwr_low),
      .start_i(start), .backup_supply_strap_i(backup), .normal_power_strap_i(normal),
      .first_output_channel_o(outv[0]), .dac_ch1_o(outv[1]), .dac_ch2_o(outv[2]),
      .dac_ch3_o(outv[3]));
   qdac_ctrl_model ctrl (.core_clk_i(core_clk_i), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Pins and read-back both compared against the model
   task automatic chk_all();
      logic [31:0] d;
      for (int c = 0; c < 4; c++)
      begin
         chk("channel pin", mdl[c], {22'h0, outv[c]});
         ctrl.rd_reg(8'h04 + 8'(4 * c), d);
         chk("channel read", mdl[c], d);
      end
   endtask
   // Model: a load counts only at offset 0 with power good
   task automatic load(input logic [7:0] a, input int s, input int v);
      ctrl.wr_word(a, s[1:0], v[9:0]);
      if (a == 8'h00 && pwr_low == 1'b0)
      begin
         mdl[s] = v;
         words.push_back(s * 1024 + v);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   initial
   begin
      repeat (60000) @(posedge core_clk_i);
      fails++;
      report_and_stop();
   end
   initial
   begin
      rst_i   = 1'b1;
      pwr_low = 1'b0;
      start   = 1'b0;
      backup  = 1'b0;
      normal  = 1'b1;
      mdl     = '{0, 0, 0, 0};
      words.push_back(0);
      fails   = 0;
      checked = 0;
      void'($urandom(32'hB4EA));
      repeat (16) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk_all();
      // Code points first, then random words over every select
      for (int i = 0; i < 8; i++)
      begin
         load(8'h00, i % 4, (i == 0) ? qdac_pkg::CODE_ZERO : (i == 1) ? qdac_pkg::CODE_HALF
            : (i == 2) ? qdac_pkg::CODE_FULL : int'($urandom % 1024));
         chk_all();
      end
      ctrl.rd_reg(8'h00, rv);
      chk("load word", words[$], rv);
      load(8'h08, 1, 'h155);
      chk_all();
      ctrl.rd_reg(8'h18, rv);
      chk("unmapped read", 0, rv);
      pwr_low <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      load(8'h00, 2, 'h0AA);
      chk_all();
      ctrl.rd_reg(8'h14, rv);
      chk("status", 32'h00000009, rv);
      pwr_low <= 1'b0;
      backup  <= 1'b1;
      normal  <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      start <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      // Start and backup strap both seen, normal strap absent
      ctrl.rd_reg(8'h14, rv);
      chk("status", 32'h00000006, rv);
      start <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk_all();
      backup <= 1'b0;
      normal <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      start <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      start <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      mdl = '{0, 0, 0, 0};
      chk_all();
      load(8'h00, 3, 'h3FF);
      chk_all();
      report_and_stop();
   end
endmodule
